/* File: common/avbarb_defs.vh */
`ifndef AVBARB_DEFS_VH
`define AVBARB_DEFS_VH

// Slope and credit widths
`define AVBARB_SLOPE_W 14
`define AVBARB_CREDIT_W 24
// Slope reset values for a 75% AV share
`define AVBARB_SEND_SLOPE_RST 14'h1800
`define AVBARB_IDLE_SLOPE_RST 14'h0800
// Fixed credit saturation bounds
`define AVBARB_CREDIT_HI 24'h0fffff
`define AVBARB_CREDIT_LO 24'hf00000
// Largest legacy frame, VLAN tagged, no jumbo
`define AVBARB_LEGACY_MAX_LEN 11'h5f2
// Arbiter states
`define AVBARB_ST_IDLE 3'h0
`define AVBARB_ST_AV 3'h1
`define AVBARB_ST_PTP 3'h2
`define AVBARB_ST_LEG 3'h3
`define AVBARB_ST_DROP 3'h4
// Source codes on the status port
`define AVBARB_SRC_NONE 2'h0
`define AVBARB_SRC_AV 2'h1
`define AVBARB_SRC_PTP 2'h2
`define AVBARB_SRC_LEG 2'h3

`endif

/* File: design/avbarb_credit.v */
`timescale 1ns/1ps
`include "avbarb_defs.vh"

module avbarb_credit (
  input wire sys_clk_in, // 50 MHz clock
  input wire rst_in, // Synchronous reset, active high
  input wire av_queued_in, // AV frame waiting or in flight
  input wire gain_byte_in, // One byte time of non-AV traffic
  input wire drain_byte_in, // One AV byte accepted
  input wire [`AVBARB_SLOPE_W-1:0] credit_gain_rate_in, // Per-byte gain
  input wire [`AVBARB_SLOPE_W-1:0] credit_drain_rate_in, // Per-byte drain
  output wire [`AVBARB_CREDIT_W-1:0] credit_out, // Signed credit
  output wire av_eligible_out // Credit is zero or above
);

  localparam CW = `AVBARB_CREDIT_W;
  localparam SW = CW + 2;

  reg [CW-1:0] credit_reg;
  reg [CW-1:0] credit_next;
  reg [SW-1:0] sum;
  wire [SW-1:0] credit_ext;
  wire [SW-1:0] gain_ext;
  wire [SW-1:0] drain_ext;
  wire [SW-1:0] hi_ext;
  wire [SW-1:0] lo_ext;
  wire [CW-1:0] credit_upper_bound;
  wire [CW-1:0] credit_lower_bound;

  assign credit_upper_bound = `AVBARB_CREDIT_HI;
  assign credit_lower_bound = `AVBARB_CREDIT_LO;
  // Wide enough that one step never wraps before saturation
  assign credit_ext = {{2{credit_reg[CW-1]}}, credit_reg};
  assign gain_ext = {{(SW-`AVBARB_SLOPE_W){1'b0}}, credit_gain_rate_in};
  assign drain_ext = {{(SW-`AVBARB_SLOPE_W){1'b0}}, credit_drain_rate_in};
  assign hi_ext = {{2{credit_upper_bound[CW-1]}}, credit_upper_bound};
  assign lo_ext = {{2{credit_lower_bound[CW-1]}}, credit_lower_bound};

  always @* begin
    sum = credit_ext;
    if (drain_byte_in) begin
      sum = credit_ext - drain_ext;
    end else if (gain_byte_in && av_queued_in) begin
      sum = credit_ext + gain_ext;
    end
    if ($signed(sum) > $signed(hi_ext)) begin
      credit_next = credit_upper_bound;
    end else if ($signed(sum) < $signed(lo_ext)) begin
      credit_next = credit_lower_bound;
    end else begin
      credit_next = sum[CW-1:0];
    end
    // Positive credit is lost when nothing waits, debt stays
    if (!av_queued_in && !credit_next[CW-1]) begin
      credit_next = {CW{1'b0}};
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      credit_reg <= {CW{1'b0}};
    end else begin
      credit_reg <= credit_next;
    end
  end

  assign credit_out = credit_reg;
  assign av_eligible_out = ~credit_reg[CW-1];

endmodule

/* File: design/avbarb_arbiter.v */
`timescale 1ns/1ps
`include "avbarb_defs.vh"

module avbarb_arbiter (
  input wire sys_clk_in, // 50 MHz clock
  input wire rst_in, // Synchronous reset, active high
  input wire slope_write_in, // Load both slope registers
  input wire [`AVBARB_SLOPE_W-1:0] send_slope_ctrl_in, // Value for gain register
  input wire [`AVBARB_SLOPE_W-1:0] idle_slope_ctrl_in, // Value for drain register
  input wire [7:0] av_tdata_in, // AV byte
  input wire av_source_frame_valid_in, // AV byte valid, frame queued
  input wire av_tlast_in, // Last AV byte
  output wire av_tready_out, // AV byte taken
  input wire [7:0] ptp_tdata_in, // PTP buffer byte
  input wire ptp_tvalid_in, // PTP packet pending
  input wire ptp_tlast_in, // Last PTP byte
  output wire ptp_tready_out, // PTP byte taken
  input wire [7:0] leg_tdata_in, // Legacy byte
  input wire leg_tvalid_in, // Legacy byte valid
  input wire leg_tlast_in, // Last legacy byte
  output wire leg_tready_out, // Legacy byte taken
  output wire [7:0] mac_tdata_out, // Byte to MAC
  output wire mac_tvalid_out, // Byte valid to MAC
  output wire mac_tlast_out, // Last byte to MAC
  output wire mac_tuser_out, // Frame cut short, bad frame
  input wire mac_tready_in, // MAC takes byte
  output wire [`AVBARB_SLOPE_W-1:0] send_slope_out, // Gain register
  output wire [`AVBARB_SLOPE_W-1:0] idle_slope_out, // Drain register
  output wire [`AVBARB_CREDIT_W-1:0] credit_out, // Signed credit
  output wire av_eligible_out, // Credit zero or above
  output wire [1:0] active_source_out, // Source being sent
  output wire leg_oversize_out // Legacy frame too long, one pulse
);

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`AVBARB_SLOPE_W-1:0] send_slope_reg;
  reg [`AVBARB_SLOPE_W-1:0] idle_slope_reg;
  reg [7:0] data_reg;
  reg valid_reg;
  reg last_reg;
  reg user_reg;
  reg [10:0] leg_len_reg;
  reg oversize_reg;
  reg [1:0] src_reg;
  reg [1:0] src_next;

  wire out_free;
  wire av_take;
  wire ptp_take;
  wire leg_take;
  wire leg_cut;
  wire idle_wait;
  wire eligible;
  wire [`AVBARB_CREDIT_W-1:0] credit;

  // Gain lives in the send slope register and drain in the idle one
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      send_slope_reg <= `AVBARB_SEND_SLOPE_RST;
      idle_slope_reg <= `AVBARB_IDLE_SLOPE_RST;
    end else if (slope_write_in) begin
      send_slope_reg <= send_slope_ctrl_in;
      idle_slope_reg <= idle_slope_ctrl_in;
    end
  end

  // One output stage; a source moves only when it can land, except legacy in the drop state
  assign out_free = ~valid_reg | mac_tready_in;
  assign av_tready_out = (state_reg == `AVBARB_ST_AV) & out_free;
  assign ptp_tready_out = (state_reg == `AVBARB_ST_PTP) & out_free;
  assign leg_tready_out = ((state_reg == `AVBARB_ST_LEG) & out_free) |
                          (state_reg == `AVBARB_ST_DROP);
  assign av_take = av_tready_out & av_source_frame_valid_in;
  assign ptp_take = ptp_tready_out & ptp_tvalid_in;
  assign leg_take = (state_reg == `AVBARB_ST_LEG) & out_free & leg_tvalid_in;
  // Cut at the longest tagged frame; no jumbo support on this path
  // The cut byte carries last and user so the MAC marks the frame bad
  assign leg_cut = leg_take & ~leg_tlast_in &
                   (leg_len_reg == `AVBARB_LEGACY_MAX_LEN - 11'h001);
  // Idle link counts as byte time, else debt with no other traffic stalls AV
  assign idle_wait = (state_reg == `AVBARB_ST_IDLE) & ~eligible &
                     ~ptp_tvalid_in & ~leg_tvalid_in;

  always @* begin
    state_next = state_reg;
    src_next = src_reg;
    case (state_reg)
      `AVBARB_ST_IDLE: begin
        // Only place a source is picked
        // Debt blocks AV even while its valid is held, so legacy gets through
        if (av_source_frame_valid_in && eligible) begin
          state_next = `AVBARB_ST_AV;
          src_next = `AVBARB_SRC_AV;
        end else if (ptp_tvalid_in) begin
          state_next = `AVBARB_ST_PTP;
          src_next = `AVBARB_SRC_PTP;
        end else if (leg_tvalid_in) begin
          state_next = `AVBARB_ST_LEG;
          src_next = `AVBARB_SRC_LEG;
        end else begin
          src_next = `AVBARB_SRC_NONE;
        end
      end
      `AVBARB_ST_AV: begin
        if (av_take && av_tlast_in) begin
          state_next = `AVBARB_ST_IDLE;
        end
      end
      `AVBARB_ST_PTP: begin
        if (ptp_take && ptp_tlast_in) begin
          state_next = `AVBARB_ST_IDLE;
        end
      end
      `AVBARB_ST_LEG: begin
        if (leg_cut) begin
          state_next = `AVBARB_ST_DROP;
        end else if (leg_take && leg_tlast_in) begin
          state_next = `AVBARB_ST_IDLE;
        end
      end
      `AVBARB_ST_DROP: begin
        // Discard the tail of an oversized frame
        // Ready stays high here so the source is never left stalled mid-frame
        if (leg_tvalid_in && leg_tlast_in) begin
          state_next = `AVBARB_ST_IDLE;
        end
      end
      default: begin
        state_next = `AVBARB_ST_IDLE;
        src_next = `AVBARB_SRC_NONE;
      end
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= `AVBARB_ST_IDLE;
      src_reg <= `AVBARB_SRC_NONE;
      leg_len_reg <= 11'h000;
      oversize_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg <= src_next;
      oversize_reg <= leg_cut;
      // Counts only bytes that land, so MAC stalls never shorten a frame
      if (state_reg != `AVBARB_ST_LEG) begin
        leg_len_reg <= 11'h000;
      end else if (leg_take) begin
        leg_len_reg <= leg_len_reg + 11'h001;
      end
    end
  end

  // Refills in the cycle it empties, so a stalled MAC costs no bubble
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
      user_reg <= 1'b0;
    end else if (out_free) begin
      valid_reg <= av_take | ptp_take | leg_take;
      if (av_take) begin
        data_reg <= av_tdata_in;
        last_reg <= av_tlast_in;
        user_reg <= 1'b0;
      end else if (ptp_take) begin
        data_reg <= ptp_tdata_in;
        last_reg <= ptp_tlast_in;
        user_reg <= 1'b0;
      end else if (leg_take) begin
        data_reg <= leg_tdata_in;
        last_reg <= leg_tlast_in | leg_cut;
        user_reg <= leg_cut;
      end
    end
  end

  // Gain and drain come from the crossed slope registers
  // Bytes of a dropped tail never reach the MAC, so they earn no credit
  avbarb_credit u_credit (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .av_queued_in(av_source_frame_valid_in),
    .gain_byte_in(ptp_take | leg_take | idle_wait),
    .drain_byte_in(av_take),
    .credit_gain_rate_in(send_slope_reg),
    .credit_drain_rate_in(idle_slope_reg),
    .credit_out(credit),
    .av_eligible_out(eligible)
  );

  assign mac_tdata_out = data_reg;
  assign mac_tvalid_out = valid_reg;
  assign mac_tlast_out = last_reg;
  assign mac_tuser_out = user_reg;
  assign send_slope_out = send_slope_reg;
  assign idle_slope_out = idle_slope_reg;
  assign credit_out = credit;
  assign av_eligible_out = eligible;
  assign active_source_out = src_reg;
  assign leg_oversize_out = oversize_reg;

endmodule

/* File: tb/avbarb_arbiter_asserts.sv */
`timescale 1ns/1ps
`include "avbarb_defs.vh"
module avbarb_arbiter_chk (
  input wire sys_clk_in, // Clock
  input wire rst_in, // Reset
  input wire av_source_frame_valid_in, // AV queued
  input wire ptp_tvalid_in, // PTP pending
  input wire leg_tvalid_in, // Legacy queued
  input wire leg_tlast_in, // Legacy last byte
  input wire leg_oversize_out, // Legacy frame cut
  input wire av_tready_out, // AV taken
  input wire ptp_tready_out, // PTP taken
  input wire leg_tready_out, // Legacy taken
  input wire [`AVBARB_SLOPE_W-1:0] send_slope_out, // Gain
  input wire [`AVBARB_SLOPE_W-1:0] idle_slope_out, // Drain
  input wire [`AVBARB_CREDIT_W-1:0] credit_out, // Credit
  input wire av_eligible_out, // Eligible
  input wire [1:0] active_source_out // Source
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // The tail of a cut legacy frame is drained, not sent, so it earns nothing
  reg drop_r;
  wire drop_w = leg_oversize_out || drop_r;
  wire oth_w = ptp_tvalid_in && ptp_tready_out ||
    leg_tvalid_in && leg_tready_out && !drop_w;
  wire av_ok_w = av_source_frame_valid_in && av_eligible_out;
  always @(posedge sys_clk_in) begin
    drop_r <= !rst_in && drop_w && !(leg_tvalid_in && leg_tlast_in);
  end
  // A new source appears only at a pick edge
  sequence s_pick;
    active_source_out != 2'h0 && active_source_out != $past(active_source_out);
  endsequence
  AST_RST_SLOPE: assert property ($fell(rst_in) |-> send_slope_out == 14'h1800 &&
    idle_slope_out == 14'h0800) else $error("Slope reset values wrong");
  AST_ELIG: assert property (av_eligible_out == !credit_out[23])
    else $error("Eligible flag does not follow credit sign");
  AST_BOUND: assert property ($signed(credit_out) >= -24'sh100000 &&
    $signed(credit_out) <= 24'sh0fffff) else $error("Credit outside bounds");
  AST_DRAIN: assert property (av_source_frame_valid_in && av_tready_out &&
    $signed(credit_out) >= $signed({1'b0, idle_slope_out}) - 24'sh100000 |=>
    credit_out == $past(credit_out) - $past(idle_slope_out)) else $error("AV drain wrong");
  AST_GAIN: assert property (oth_w && av_source_frame_valid_in &&
    $signed(credit_out) <= 24'sh0fffff - $signed({1'b0, send_slope_out}) |=>
    credit_out == $past(credit_out) + $past(send_slope_out)) else $error("Gain wrong");
  AST_CLEAR: assert property (!av_source_frame_valid_in |=>
    credit_out == 24'h000000 || credit_out[23]) else $error("Positive credit kept");
  AST_RDY_SRC: assert property ((!av_tready_out || active_source_out == 2'h1) &&
    (!ptp_tready_out || active_source_out == 2'h2) &&
    (!leg_tready_out || active_source_out == 2'h3)) else $error("Ready from wrong source");
  AST_PICK_AV: assert property (s_pick |->
    (active_source_out == 2'h1) == $past(av_ok_w)) else $error("AV pick wrong");
  AST_PICK_PTP: assert property (s_pick |->
    !$past(!av_ok_w && ptp_tvalid_in) || active_source_out == 2'h2) else $error("PTP pick");
  AST_PICK_LEG: assert property (s_pick |->
    !$past(!av_ok_w && !ptp_tvalid_in) || active_source_out == 2'h3) else $error("Leg pick");
endmodule
bind avbarb_arbiter avbarb_arbiter_chk i_avbarb_arbiter_chk (.sys_clk_in, .rst_in,
  .av_source_frame_valid_in, .ptp_tvalid_in, .leg_tvalid_in, .leg_tlast_in,
  .leg_oversize_out, .av_tready_out,
  .ptp_tready_out, .leg_tready_out, .send_slope_out, .idle_slope_out, .credit_out,
  .av_eligible_out, .active_source_out);

/* File: tb/avbarb_src_model.sv */
`timescale 1ns/1ps
module avbarb_src_model (
  input wire sys_clk_in, // Clock
  input wire rst_in, // Reset
  input wire start_in, // Load a batch
  input wire [3:0] nfrm_in, // Frames in batch
  input wire [11:0] len_in, // Bytes per frame
  input wire tready_in, // Byte taken
  output reg tvalid_out, // Byte valid
  output reg [7:0] tdata_out, // Byte
  output wire tlast_out, // Last byte
  output reg [3:0] left_out // Frames to go
);
  reg [11:0] len_reg;
  reg [11:0] idx_reg;
  // Idle lines keep toggling so stale values are never trusted
  assign tlast_out = tvalid_out ? idx_reg == len_reg - 12'h001 : ~tdata_out[0];
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      tvalid_out <= 1'b0;
      tdata_out <= 8'h00;
      left_out <= 4'h0;
    end else if (start_in) begin
      left_out <= nfrm_in;
      len_reg <= len_in;
      idx_reg <= 12'h000;
      tvalid_out <= 1'b1;
    end else if (tvalid_out && tready_in) begin
      tdata_out <= tdata_out + 8'h01;
      idx_reg <= tlast_out ? 12'h000 : idx_reg + 12'h001;
      if (tlast_out) begin
        left_out <= left_out - 4'h1;
        tvalid_out <= left_out != 4'h1;
      end
    end else if (!tvalid_out) begin
      tdata_out <= ~tdata_out;
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  reg sys_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg slope_write_in = 1'b0;
  reg mac_tready_in = 1'b0;
  reg [13:0] send_slope_ctrl_in = 14'h0000;
  reg [13:0] idle_slope_ctrl_in = 14'h0000;
  reg [2:0] go = 3'h0;
  reg [3:0] nf [0:2];
  reg [11:0] ln [0:2];
  reg [1:0] cyc = 2'h0;
  reg [2:0] sof = 3'h7;
  reg msof = 1'b1;
  reg [7:0] exp_d = 8'h00;
  integer n_fail = 0, num_checks = 0, n_user = 0, n_big = 0, i, k;
  reg [1:0] q [$];
  reg [1:0] exp_q [0:7] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h1, 2'h3};
  wire [2:0] sv, sl, rdy;
  wire [7:0] sd [0:2];
  wire [3:0] left [0:2];
  wire mac_tvalid_out, mac_tlast_out, mac_tuser_out, leg_oversize_out;
  wire [7:0] mac_tdata_out;
  wire [13:0] send_slope_out, idle_slope_out;
  wire [23:0] credit_out;
  wire [1:0] active_source_out;
  avbarb_arbiter i_avbarb_arbiter (
    .sys_clk_in, .rst_in, .slope_write_in, .send_slope_ctrl_in, .idle_slope_ctrl_in,
    .av_tdata_in(sd[0]), .av_source_frame_valid_in(sv[0]), .av_tlast_in(sl[0]),
    .av_tready_out(rdy[0]), .ptp_tdata_in(sd[1]), .ptp_tvalid_in(sv[1]),
    .ptp_tlast_in(sl[1]), .ptp_tready_out(rdy[1]), .leg_tdata_in(sd[2]),
    .leg_tvalid_in(sv[2]), .leg_tlast_in(sl[2]), .leg_tready_out(rdy[2]),
    .mac_tdata_out, .mac_tvalid_out, .mac_tlast_out, .mac_tuser_out, .mac_tready_in,
    .send_slope_out, .idle_slope_out, .credit_out, .av_eligible_out(),
    .active_source_out, .leg_oversize_out);
  for (genvar g = 0; g < 3; g++) begin : g_src
    avbarb_src_model i_avbarb_src_model (.sys_clk_in, .rst_in, .start_in(go[g]),
      .nfrm_in(nf[g]), .len_in(ln[g]), .tready_in(rdy[g]), .tvalid_out(sv[g]),
      .tdata_out(sd[g]), .tlast_out(sl[g]), .left_out(left[g]));
  end
  initial forever #10 sys_clk_in = ~sys_clk_in;
  // MAC stalls one cycle in four
  always @(negedge sys_clk_in) begin
    cyc <= cyc + 2'h1;
    mac_tready_in <= cyc != 2'h3;
  end
  always @(posedge sys_clk_in) begin
    if (leg_oversize_out === 1'b1) n_big = n_big + 1;
    // Frame order is taken at the sources; the source code moves on at the pick
    for (k = 0; k < 3; k++) begin
      if (sv[k] === 1'b1 && rdy[k] === 1'b1) begin
        if (sof[k]) begin
          q.push_back(k[1:0] + 2'h1);
          check(active_source_out, k + 1);
        end
        sof[k] = sl[k];
      end
    end
    if (mac_tvalid_out === 1'b1 && mac_tready_in) begin
      if (!msof) check(mac_tdata_out, exp_d);
      exp_d = mac_tdata_out + 8'h01;
      msof = mac_tlast_out;
      if (mac_tuser_out === 1'b1) n_user = n_user + 1;
    end
  end
  task check(input [31:0] seen, input [31:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      n_fail = n_fail + 1;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cfg(input integer s, input [3:0] n, input [11:0] l);
    nf[s] = n;
    ln[s] = l;
  endtask
  task slopes(input [13:0] g, input [13:0] d);
    @(negedge sys_clk_in);
    send_slope_ctrl_in = g;
    idle_slope_ctrl_in = d;
    slope_write_in = 1'b1;
    @(negedge sys_clk_in);
    slope_write_in = 1'b0;
  endtask
  task run(input [2:0] m);
    @(negedge sys_clk_in) go = m;
    @(negedge sys_clk_in) go = 3'h0;
    for (i = 0; i < 4000 && (left[0] | left[1] | left[2] | {3'h0, mac_tvalid_out}) !== 4'h0;
      i++) @(negedge sys_clk_in);
    if (i == 4000) begin
      n_fail = n_fail + 1;
      stop_test;
    end
    repeat (2) @(negedge sys_clk_in);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_in);
    rst_in = 1'b0;
    check(send_slope_out, 14'h1800);
    check(idle_slope_out, 14'h0800);
    check(credit_out, 24'h000000);
    // Two AV frames of four, PTP and legacy of one byte each
    cfg(0, 4'h2, 12'h004);
    cfg(1, 4'h1, 12'h001);
    cfg(2, 4'h1, 12'h001);
    run(3'h7);
    check(credit_out, 24'hfff000);
    // AV shares 0 and 25 percent; gain goes to the send slope port
    slopes(14'h0000, 14'h2000);
    check(send_slope_out, 14'h0000);
    check(idle_slope_out, 14'h2000);
    slopes(14'h0800, 14'h1800);
    check(send_slope_out, 14'h0800);
    check(idle_slope_out, 14'h1800);
    cfg(0, 4'h1, 12'h0c8);
    run(3'h1);
    check(credit_out, 24'hf00000);
    cfg(0, 4'h1, 12'h001);
    cfg(2, 4'h1, 12'h258);
    run(3'h5);
    check(credit_out, 24'h000000);
    cfg(2, 4'h1, 12'h5fa);
    run(3'h4);
    check(n_user, 1);
    check(n_big, 1);
    check(q.size(), 8);
    for (i = 0; i < 8; i++) check(q[i], exp_q[i]);
    stop_test;
  end
endmodule
